// [lcdh_port.sv]
// Host instruction port of a character display controller.
//
// Function
// - Narrow bus uses only upper four lines
// - Narrow byte: high nibble, then low
// - Narrow status read takes two nibble reads
// - Wide bus moves byte in one access
// - Busy held through power-on initialisation
// - Init clears, sets wide, one line, small
// - Init turns display off, increment, no shift
// - Only instruction and data registers reachable
// - While busy only status read accepted
// - Busy flag high during instruction execution
// - Clear blanks memory, address counter zero
// - Home zeroes address counter and shift
// - Entry mode stores direction and shift
// - Display control stores on, cursor, blink
// - Shift moves cursor or display, direction
// - Function stores width, lines, font
// - Pattern address load targets pattern memory
// - Display address load targets display memory
// - Status read: busy bit 7, counter
// - Data access steps counter by one
// - Shift-on-access shifts with data write
// - Data write stores at address counter
// - Data read returns memory at counter
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module lcdh_port
   import lcdh_pkg::*;
#(
   parameter int INIT_CYCLES = int'(INIT_CYC),
   parameter int HOME_CYCLES = int'(HOME_CYC)
)
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       register_select_line_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   input  wire logic [7:0] data_in,
   output logic      [7:0] rd_data_out,
   output logic            busy_flag_out,
   output logic      [6:0] address_counter_out,
   output logic            display_on_out,
   output logic            cursor_on_out,
   output logic            blink_out,
   output logic            bus_width_flag_out,
   output logic            two_lines_out,
   output logic            tall_font_out,
   output logic      [6:0] display_shift_out
);
   lcdh_state_e      state_r;
   lcdh_state_e      state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             nib_r;
   logic [3:0]       hi_r;
   logic [7:0]       rhold_r;
   logic             clr_r;
   logic             dir_r;
   logic             shf_r;
   logic             pat_sel_r;
   logic [6:0]       ac_nxt;
   logic [6:0]       shift_nxt;
   logic             ok_w;
   logic             take_w;
   logic             done_w;
   logic [7:0]       wbyte_w;
   logic [7:0]       rbyte_w;
   logic [7:0]       mem_rdata_w;
   logic             ins_w;
   logic             dwr_w;
   logic             drd_w;
   logic             op_clear_w;
   logic             op_home_w;
   logic             op_entry_w;
   logic             op_disp_w;
   logic             op_shift_w;
   logic             op_func_w;
   logic             op_pat_w;
   logic             op_addr_w;
   logic             step_w;
   logic [6:0]       ac_step_w;

   // ----------------------------------------------------------------------
   // Access acceptance and nibble pairing
   // ----------------------------------------------------------------------
   // While busy, only the status read gets through; others are dropped.
   assign ok_w    = (state_r == ST_IDLE) ||
                    (rd_in && register_select_line_in == SEL_INSTR);
   assign take_w  = (wr_in || rd_in) && ok_w;
   assign done_w  = take_w && (bus_width_flag_out || nib_r);
   assign wbyte_w = bus_width_flag_out ? data_in : {hi_r, data_in[7:4]};

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         nib_r <= 1'b0;
      end else if (bus_width_flag_out) begin
         nib_r <= 1'b0;
      end else if (take_w) begin
         nib_r <= ~nib_r;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hi_r <= 4'h0;
      end else if (take_w && wr_in && !bus_width_flag_out && !nib_r) begin
         hi_r <= data_in[7:4];
      end
   end

   // ----------------------------------------------------------------------
   // Instruction decode by highest set bit
   // ----------------------------------------------------------------------
   assign ins_w      = done_w && wr_in && register_select_line_in == SEL_INSTR;
   assign dwr_w      = done_w && wr_in && register_select_line_in == SEL_DATA;
   assign drd_w      = done_w && rd_in && register_select_line_in == SEL_DATA;
   assign op_clear_w = ins_w && wbyte_w == CLEAR_CODE;
   assign op_home_w  = ins_w && wbyte_w[7:1] == 7'h01;
   assign op_entry_w = ins_w && wbyte_w[7:2] == 6'h01;
   assign op_disp_w  = ins_w && wbyte_w[7:3] == 5'h01;
   assign op_shift_w = ins_w && wbyte_w[7:4] == 4'h1;
   assign op_func_w  = ins_w && wbyte_w[7:5] == 3'h1;
   assign op_pat_w   = ins_w && wbyte_w[7:6] == 2'h1;
   assign op_addr_w  = ins_w && wbyte_w[7];
   assign step_w     = dwr_w || drd_w;

   // ----------------------------------------------------------------------
   // Busy sequencing
   // ----------------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_INIT, ST_BUSY: begin
            if (cnt_r <= CNT_W'(1)) begin
               state_nxt = ST_IDLE;
               cnt_nxt   = '0;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         ST_IDLE: begin
            if (op_clear_w || op_home_w) begin
               state_nxt = ST_BUSY;
               cnt_nxt   = CNT_W'(HOME_CYCLES);
            end else if (ins_w || step_w) begin
               state_nxt = ST_BUSY;
               cnt_nxt   = CNT_W'(EXEC_CYC);
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            cnt_nxt   = '0;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_r       <= ST_INIT;
         cnt_r         <= CNT_W'(INIT_CYCLES);
         busy_flag_out <= 1'b1;
      end else begin
         state_r       <= state_nxt;
         cnt_r         <= cnt_nxt;
         busy_flag_out <= (state_nxt != ST_IDLE);
      end
   end

   // Power-on blanking runs in the first cycle after reset release.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         clr_r <= 1'b1;
      end else begin
         clr_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Mode flags
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         dir_r <= RST_DIR;
         shf_r <= RST_SHF;
      end else if (op_entry_w) begin
         dir_r <= wbyte_w[ENT_DIR_BIT];
         shf_r <= wbyte_w[ENT_SHF_BIT];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         display_on_out <= RST_DISP;
         cursor_on_out  <= RST_DISP;
         blink_out      <= RST_DISP;
      end else if (op_disp_w) begin
         display_on_out <= wbyte_w[DSP_ON_BIT];
         cursor_on_out  <= wbyte_w[DSP_CUR_BIT];
         blink_out      <= wbyte_w[DSP_BLK_BIT];
      end
   end

   // A width change takes effect for the next access, which in narrow mode is a high nibble.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bus_width_flag_out <= RST_WIDE;
         two_lines_out      <= RST_LINES;
         tall_font_out      <= RST_FONT;
      end else if (op_func_w) begin
         bus_width_flag_out <= wbyte_w[FN_DL_BIT];
         two_lines_out      <= wbyte_w[FN_N_BIT];
         tall_font_out      <= wbyte_w[FN_F_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Address counter and display shift
   // ----------------------------------------------------------------------
   assign ac_step_w = dir_r ? address_counter_out + 7'd1 : address_counter_out - 7'd1;

   always_comb begin
      ac_nxt = address_counter_out;
      if (op_clear_w || op_home_w) begin
         ac_nxt = 7'h00;
      end else if (op_addr_w) begin
         ac_nxt = wbyte_w[6:0];
      end else if (op_pat_w) begin
         ac_nxt = {1'b0, wbyte_w[5:0]};
      end else if (op_shift_w && !wbyte_w[SHF_SC_BIT]) begin
         ac_nxt = wbyte_w[SHF_RL_BIT] ? address_counter_out + 7'd1
                                      : address_counter_out - 7'd1;
      end else if (step_w) begin
         ac_nxt = pat_sel_r ? {1'b0, ac_step_w[5:0]} : ac_step_w;
      end
   end

   // Shifting left raises the offset; shifting right lowers it.
   always_comb begin
      shift_nxt = display_shift_out;
      if (op_clear_w || op_home_w) begin
         shift_nxt = 7'h00;
      end else if (op_shift_w && wbyte_w[SHF_SC_BIT]) begin
         shift_nxt = wbyte_w[SHF_RL_BIT] ? display_shift_out - 7'd1
                                         : display_shift_out + 7'd1;
      end else if (step_w && shf_r && !pat_sel_r) begin
         shift_nxt = dir_r ? display_shift_out + 7'd1
                           : display_shift_out - 7'd1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         address_counter_out <= 7'h00;
         display_shift_out   <= 7'h00;
      end else begin
         address_counter_out <= ac_nxt;
         display_shift_out   <= shift_nxt;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pat_sel_r <= 1'b0;
      end else if (op_pat_w) begin
         pat_sel_r <= 1'b1;
      end else if (op_addr_w || op_clear_w || op_home_w) begin
         pat_sel_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Memories
   // ----------------------------------------------------------------------
   lcdh_mem u_mem (
      .clk_in     (clk_in),
      .clear_in   (clr_r || op_clear_w),
      .wr_in      (dwr_w),
      .pat_sel_in (pat_sel_r),
      .addr_in    (address_counter_out),
      .wdata_in   (wbyte_w),
      .rdata_out  (mem_rdata_w)
   );

   // ----------------------------------------------------------------------
   // Read data path
   // ----------------------------------------------------------------------
   assign rbyte_w = (register_select_line_in == SEL_DATA) ? mem_rdata_w
                  : {busy_flag_out, address_counter_out};

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rhold_r <= 8'h00;
      end else if (take_w && rd_in && !bus_width_flag_out && !nib_r) begin
         rhold_r <= rbyte_w;
      end
   end

   // Data stand only in the cycle after the read strobe.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_data_out <= 8'h00;
      end else if (take_w && rd_in) begin
         if (bus_width_flag_out) begin
            rd_data_out <= rbyte_w;
         end else if (!nib_r) begin
            rd_data_out <= {rbyte_w[7:4], 4'h0};
         end else begin
            rd_data_out <= {rhold_r[3:0], 4'h0};
         end
      end else begin
         rd_data_out <= 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence hi_nib_s;
      take_w && wr_in && !bus_width_flag_out && !nib_r;
   endsequence

   sequence lo_nib_s;
      wr_in && ok_w && register_select_line_in == SEL_INSTR;
   endsequence

   init_busy_a: assert property ($fell(rst_in) |-> busy_flag_out [*8])
      else $error("busy flag dropped during initialisation");

   busy_refuse_a: assert property (state_r != ST_IDLE && wr_in
         |=> $stable(address_counter_out) && $stable(display_on_out))
      else $error("access accepted while busy");

   exec_busy_a: assert property (ins_w |=> busy_flag_out [*8])
      else $error("busy flag not held after instruction");

   status_read_a: assert property (rd_in && ok_w && bus_width_flag_out &&
         register_select_line_in == SEL_INSTR
         |=> rd_data_out == {$past(busy_flag_out), $past(address_counter_out)})
      else $error("status read returned wrong value");

   clear_home_a: assert property (op_clear_w
         |=> address_counter_out == 7'h00 && display_shift_out == 7'h00
             && !pat_sel_r)
      else $error("clear left counter or shift nonzero");

   nibble_pair_a: assert property (hi_nib_s |=> $stable(address_counter_out)
         && state_r == ST_IDLE && nib_r)
      else $error("high nibble completed a byte");

   pair_order_a: assert property (hi_nib_s ##[1:2] lo_nib_s
         |=> busy_flag_out && !nib_r)
      else $error("low nibble mishandled");

   step_up_a: assert property (dwr_w && dir_r && !pat_sel_r
         |=> address_counter_out == $past(address_counter_out) + 7'd1)
      else $error("counter did not step after data write");

   entry_store_a: assert property (op_entry_w
         |=> dir_r == $past(wbyte_w[ENT_DIR_BIT]) && shf_r == $past(wbyte_w[0]))
      else $error("entry mode flags not stored");

   func_store_a: assert property (op_func_w
         |=> bus_width_flag_out == $past(wbyte_w[FN_DL_BIT]))
      else $error("bus width not stored");
endmodule

// [lcdh_pkg.sv]
// Package with constants of the display controller host instruction port.
package lcdh_pkg;
   // ----------------------------------------------------------------------
   // Clock and execution times
   // ----------------------------------------------------------------------
   localparam longint CLK_KHZ     = 20000;
   localparam longint T_INIT_NS   = 10000000;
   localparam longint T_HOME_NS   = 1520000;
   localparam longint T_EXEC_NS   = 37000;
   localparam longint INIT_CYC    = (T_INIT_NS * CLK_KHZ + 999999) / 1000000;
   localparam longint HOME_CYC    = (T_HOME_NS * CLK_KHZ + 999999) / 1000000;
   localparam longint EXEC_CYC    = (T_EXEC_NS * CLK_KHZ + 999999) / 1000000;
   localparam int     CNT_W       = 18;

   // ----------------------------------------------------------------------
   // Register select codes and memory sizes
   // ----------------------------------------------------------------------
   localparam logic   SEL_INSTR   = 1'b0;
   localparam logic   SEL_DATA    = 1'b1;
   localparam int     DISP_DEPTH  = 80;
   localparam int     PAT_DEPTH   = 64;
   localparam logic [7:0] BLANK_CODE = 8'h20;
   localparam logic [7:0] CLEAR_CODE = 8'h01;

   // ----------------------------------------------------------------------
   // Instruction field positions
   // ----------------------------------------------------------------------
   localparam int     ENT_DIR_BIT = 1;
   localparam int     ENT_SHF_BIT = 0;
   localparam int     DSP_ON_BIT  = 2;
   localparam int     DSP_CUR_BIT = 1;
   localparam int     DSP_BLK_BIT = 0;
   localparam int     SHF_SC_BIT  = 3;
   localparam int     SHF_RL_BIT  = 2;
   localparam int     FN_DL_BIT   = 4;
   localparam int     FN_N_BIT    = 3;
   localparam int     FN_F_BIT    = 2;

   // ----------------------------------------------------------------------
   // Values applied by power-on initialisation
   // ----------------------------------------------------------------------
   localparam logic   RST_DIR     = 1'b1;
   localparam logic   RST_SHF     = 1'b0;
   localparam logic   RST_DISP    = 1'b0;
   localparam logic   RST_WIDE    = 1'b1;
   localparam logic   RST_LINES   = 1'b0;
   localparam logic   RST_FONT    = 1'b0;

   typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_BUSY} lcdh_state_e;
endpackage

// [lcdh_mem.sv]
// Display memory with a one-cycle blanking clear, and pattern memory with no clear.
`timescale 1ns/1ps
module lcdh_mem
   import lcdh_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       clear_in,
   input  wire logic       wr_in,
   input  wire logic       pat_sel_in,
   input  wire logic [6:0] addr_in,
   input  wire logic [7:0] wdata_in,
   output logic      [7:0] rdata_out
);
   logic [7:0] disp_mem [DISP_DEPTH];
   logic [7:0] pat_mem  [PAT_DEPTH];

   // ----------------------------------------------------------------------
   // Storage, one process per entry
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < DISP_DEPTH; i++) begin : g_disp
      always_ff @(posedge clk_in) begin
         if (clear_in) begin
            disp_mem[i] <= BLANK_CODE;
         end else if (wr_in && !pat_sel_in && addr_in == 7'(i)) begin
            disp_mem[i] <= wdata_in;
         end
      end
   end

   for (genvar j = 0; j < PAT_DEPTH; j++) begin : g_pat
      always_ff @(posedge clk_in) begin
         if (wr_in && pat_sel_in && addr_in[5:0] == 6'(j)) begin
            pat_mem[j] <= wdata_in;
         end
      end
   end

   // Addresses beyond the display memory read as zero.
   always_comb begin
      rdata_out = 8'h00;
      if (pat_sel_in) begin
         rdata_out = pat_mem[addr_in[5:0]];
      end else if (addr_in < 7'(DISP_DEPTH)) begin
         rdata_out = disp_mem[addr_in];
      end
   end
endmodule

// [lcdh_host_model.sv]
// Host bus master model driving the instruction port in wide or narrow mode.
`timescale 1ns/1ps
module lcdh_host_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] rd_data_in,
   output logic            rs_out,
   output logic            wr_out,
   output logic            rd_out,
   output logic      [7:0] data_out
);
   logic narrow;

   initial begin
      narrow = 1'b0;
      rs_out = 1'b0;
      wr_out = 1'b0;
      rd_out = 1'b0;
      data_out = 8'h00;
   end

   // One strobe cycle; a released bus shows the inverse of v.
   task automatic xfer(input logic s, input logic r, input logic [7:0] v,
                       output logic [7:0] got);
      @(posedge clk_in);
      rs_out <= s;
      rd_out <= r;
      wr_out <= ~r;
      data_out <= r ? ~data_out : v;
      @(posedge clk_in);
      rd_out <= 1'b0;
      wr_out <= 1'b0;
      data_out <= ~v;
      #1;
      got = rd_data_in;
   endtask

   task automatic access(input logic s, input logic r, input logic [7:0] v,
                         output logic [7:0] got);
      logic [7:0] hi;
      logic [7:0] lo;
      if (narrow) begin
         xfer(s, r, {v[7:4], ~v[7:4]}, hi);
         xfer(s, r, {v[3:0], v[7:4]}, lo);
         got = {hi[7:4], lo[7:4]};
      end else begin
         xfer(s, r, v, got);
      end
   endtask

   task automatic wait_idle(output logic ok);
      logic [7:0] st;
      ok = 1'b0;
      for (int i = 0; i < 2000 && !ok; i++) begin
         access(1'b0, 1'b1, 8'h00, st);
         ok = (st[7] === 1'b0);
      end
   endtask
endmodule

// [lcd_controller_host_instruction_port_tb_top.sv]
// Self-checking testbench of the host instruction port.
`timescale 1ns/1ps
module lcd_controller_host_instruction_port_tb_top;
   import lcdh_pkg::*;
   localparam int INIT_N = 20;
   localparam int HOME_N = 12;
   logic       clk_in;
   logic       rst_in;
   logic       rs;
   logic       wr;
   logic       rd;
   logic       busy;
   logic       on;
   logic       cur;
   logic       blk;
   logic       wide;
   logic       two;
   logic       tall;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] g;
   logic [6:0] ac;
   logic [6:0] shift;
   int         num_errors;
   int         n_compared;

   initial clk_in = 1'b0;
   always #25 clk_in = ~clk_in;

   lcdh_host_model host_u (.clk_in(clk_in), .rd_data_in(rdata), .rs_out(rs),
                           .wr_out(wr), .rd_out(rd), .data_out(wdata));

   lcdh_port #(.INIT_CYCLES(INIT_N), .HOME_CYCLES(HOME_N)) dut_u (
      .clk_in(clk_in), .rst_in(rst_in), .register_select_line_in(rs),
      .wr_in(wr), .rd_in(rd), .data_in(wdata), .rd_data_out(rdata),
      .busy_flag_out(busy), .address_counter_out(ac), .display_on_out(on),
      .cursor_on_out(cur), .blink_out(blk), .bus_width_flag_out(wide),
      .two_lines_out(two), .tall_font_out(tall), .display_shift_out(shift));

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask

   task automatic idle();
      logic ok;
      host_u.wait_idle(ok);
      chk(16'(ok), 16'h1);
   endtask

   task automatic put(input logic s, input logic [7:0] v);
      host_u.access(s, 1'b0, v, g);
      idle();
   endtask

   task automatic get();
      host_u.access(SEL_DATA, 1'b1, 8'h00, g);
      idle();
   endtask

   // Counts the cycles that busy stays high after an instruction.
   task automatic busy_len(input logic [7:0] code, input int n);
      int cnt;
      host_u.access(SEL_INSTR, 1'b0, code, g);
      cnt = 0;
      while (busy === 1'b1 && cnt < 40000) begin
         @(posedge clk_in);
         #1;
         cnt++;
      end
      chk(16'(cnt), 16'(n));
   endtask

   task automatic t_init();
      #1;
      chk(16'(busy), 16'h1);
      chk(16'({wide, two, tall}), 16'h4);
      chk(16'({on, cur, blk}), 16'h0);
      host_u.access(SEL_INSTR, 1'b1, 8'h00, g);
      chk(16'(g), 16'h80);
      host_u.access(SEL_INSTR, 1'b0, 8'h0f, g);
      idle();
      chk(16'(on), 16'h0);
      get();
      chk(16'(g), 16'(BLANK_CODE));
      chk(16'(ac), 16'h1);
      $display("test init done");
   endtask

   task automatic t_ctrl();
      put(SEL_INSTR, 8'h0f);
      chk(16'({on, cur, blk}), 16'h7);
      put(SEL_INSTR, 8'h0d);
      chk(16'({on, cur, blk}), 16'h5);
      host_u.access(SEL_INSTR, 1'b0, 8'h0a, g);
      host_u.access(SEL_INSTR, 1'b0, 8'h08, g);
      idle();
      chk(16'({on, cur, blk}), 16'h2);
      put(SEL_INSTR, 8'h3c);
      chk(16'({wide, two, tall}), 16'h7);
      put(SEL_INSTR, 8'h30);
      chk(16'({wide, two, tall}), 16'h4);
      $display("test control done");
   endtask

   task automatic t_mem();
      put(SEL_INSTR, 8'h85);
      chk(16'(ac), 16'h5);
      put(SEL_DATA, 8'h41);
      chk(16'(ac), 16'h6);
      put(SEL_INSTR, 8'h04);
      put(SEL_DATA, 8'h42);
      chk(16'(ac), 16'h5);
      get();
      chk(16'(g), 16'h41);
      chk(16'(ac), 16'h4);
      put(SEL_INSTR, 8'h86);
      get();
      chk(16'(g), 16'h42);
      put(SEL_INSTR, 8'h06);
      put(SEL_INSTR, 8'h7f);
      chk(16'(ac), 16'h3f);
      put(SEL_DATA, 8'h99);
      chk(16'(ac), 16'h0);
      put(SEL_INSTR, 8'h7f);
      get();
      chk(16'(g), 16'h99);
      put(SEL_INSTR, 8'h80);
      get();
      chk(16'(g), 16'(BLANK_CODE));
      $display("test memory done");
   endtask

   task automatic t_shift();
      put(SEL_INSTR, 8'h07);
      put(SEL_INSTR, 8'h80);
      put(SEL_DATA, 8'h33);
      chk(16'(shift), 16'h1);
      put(SEL_INSTR, 8'h06);
      put(SEL_INSTR, 8'h1c);
      chk(16'(shift), 16'h0);
      put(SEL_INSTR, 8'h18);
      chk(16'(shift), 16'h1);
      put(SEL_INSTR, 8'h14);
      chk(16'(ac), 16'h2);
      put(SEL_INSTR, 8'h10);
      chk(16'(ac), 16'h1);
      busy_len(8'h03, HOME_N);
      chk(16'({ac, shift}), 16'h0);
      get();
      chk(16'(g), 16'h33);
      busy_len(8'h0c, int'(EXEC_CYC));
      $display("test shift done");
   endtask

   task automatic t_clear();
      put(SEL_INSTR, 8'h80);
      put(SEL_DATA, 8'h55);
      busy_len(CLEAR_CODE, HOME_N);
      chk(16'(ac), 16'h0);
      get();
      chk(16'(g), 16'(BLANK_CODE));
      $display("test clear done");
   endtask

   task automatic t_narrow();
      host_u.access(SEL_INSTR, 1'b0, 8'h28, g);
      host_u.narrow = 1'b1;
      idle();
      chk(16'({wide, two}), 16'h1);
      host_u.access(SEL_INSTR, 1'b0, 8'h8a, g);
      chk(16'(ac), 16'h0a);
      host_u.access(SEL_INSTR, 1'b1, 8'h00, g);
      chk(16'(g), 16'h8a);
      idle();
      put(SEL_DATA, 8'ha5);
      chk(16'(ac), 16'h0b);
      put(SEL_INSTR, 8'h8a);
      get();
      chk(16'(g), 16'ha5);
      put(SEL_INSTR, 8'h30);
      host_u.narrow = 1'b0;
      chk(16'(wide), 16'h1);
      $display("test narrow done");
   endtask

   task automatic summarize();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      num_errors = 0;
      n_compared = 0;
      rst_in = 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      t_init();
      t_ctrl();
      t_mem();
      t_shift();
      t_clear();
      t_narrow();
      summarize();
   end

   initial begin
      repeat (100000) @(posedge clk_in);
      num_errors++;
      summarize();
   end
endmodule
